// >>> shared/tcc_consts.svh
// Constants for the timer channel clock and trigger control block
// ============================================================
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// ============================================================
// Register offsets (byte addresses)
`define TCC_ADDR_W 8
`define TCC_OFF_CTRL 8'h00
`define TCC_OFF_MODE 8'h04
`define TCC_OFF_CMPC 8'h08
`define TCC_OFF_CV 8'h0c
`define TCC_OFF_CAPB 8'h10
`define TCC_OFF_STATUS 8'h14

// ============================================================
// Field positions
`define TCC_CTRL_EN_BIT 0
`define TCC_CTRL_DIS_BIT 1
`define TCC_CTRL_SWTRG_BIT 2
`define TCC_MODE_W 7
`define TCC_MODE_WAVE_BIT 0
`define TCC_MODE_BSTOP_BIT 1
`define TCC_MODE_BDIS_BIT 2
`define TCC_MODE_CSTOP_BIT 3
`define TCC_MODE_CDIS_BIT 4
`define TCC_MODE_CPCTRG_BIT 5
`define TCC_MODE_EXTTRG_BIT 6
`define TCC_ST_ENABLED_BIT 0
`define TCC_ST_RUN_BIT 1
`define TCC_ST_LDB_BIT 2
`define TCC_ST_CPC_BIT 3

// ============================================================
// Reset values
`define TCC_MODE_RST 7'h00
`define TCC_CMPC_RST_BIT 1'b1

`endif

// >>> shared/tcc_pkg.sv
// Types for the timer channel clock and trigger control block
package tcc_pkg;
	// Counter clock gating state, one-hot
	typedef enum logic [2:0] {
		TCC_CLK_OFF = 3'b001,
		TCC_CLK_STOP = 3'b010,
		TCC_CLK_RUN = 3'b100
	} tcc_clk_state_type;
endpackage

// >>> core/tcc_counter.sv
// Channel counter with active-edge detect and deferred trigger
`timescale 1ns/1ns
module tcc_counter import tcc_pkg::*; #(
	parameter int COUNT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sel_clk,
	input wire logic trigger,
	input wire logic clk_enabled,
	input wire logic clk_running,
	input wire logic [COUNT_W-1:0] compare_c,
	output logic active_edge,
	output logic trig_fire,
	output logic cmp_c_hit,
	output logic [COUNT_W-1:0] count
);

	logic sel_clk_prev_r;
	logic trig_pend_r;
	logic cmp_r;
	logic [COUNT_W-1:0] count_r;
	logic [COUNT_W-1:0] count_nxt;

	// ============================================================
	// Edge detect of the selected clock, sampled on pclk
	assign active_edge = sel_clk & ~sel_clk_prev_r;
	assign trig_fire = active_edge & trig_pend_r & clk_enabled;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_clk_prev_r <= 1'b0;
		end else begin
			sel_clk_prev_r <= sel_clk;
		end
	end

	// Trigger waits for the next active edge; dropped when disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_pend_r <= 1'b0;
		end else if (!clk_enabled) begin
			trig_pend_r <= 1'b0;
		end else if (trigger) begin
			trig_pend_r <= 1'b1;
		end else if (active_edge) begin
			trig_pend_r <= 1'b0;
		end
	end

	// ============================================================
	// Counting and compare with register C
	always_comb begin
		if (trig_fire) begin
			count_nxt = '0;
		end else if (active_edge && clk_running && clk_enabled) begin
			count_nxt = count_r + 1'b1;
		end else begin
			count_nxt = count_r;
		end
	end

	// Match is taken only on a counting edge, so a parked count never rehits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= '0;
			cmp_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			cmp_r <= active_edge & clk_running & clk_enabled & ~trig_fire &
				(count_nxt == compare_c);
		end
	end

	assign cmp_c_hit = cmp_r;
	assign count = count_r;

endmodule // tcc_counter

// >>> core/tcc_channel.sv
// One timer channel: APB registers, clock gating, modes and triggers
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "tcc_consts.svh"
module tcc_channel import tcc_pkg::*; #(
	parameter int COUNT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`TCC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic counter_clk,
	input wire logic sync_trigger,
	input wire logic channel_io_a_in,
	output logic channel_io_a_out,
	output logic channel_io_a_oe,
	input wire logic channel_io_b_in,
	output logic channel_io_b_out,
	output logic channel_io_b_oe
);

	// ============================================================
	// Declarations
	tcc_clk_state_type state_r, state_nxt;
	logic [`TCC_MODE_W-1:0] channel_mode_reg_r;
	logic [COUNT_W-1:0] compare_register_c_r, capture_register_b_r, count;
	logic [31:0] prdata_r, rd_mux, channel_status_reg;
	logic ldb_flag_r, cpc_flag_r, io_a_prev_r, io_b_prev_r, io_a_out_r;
	logic io_b_out_r, wr_acc, rd_acc, mapped, status_read, sw_trigger;
	logic clock_enable_cmd, clock_disable_cmd, wave_mode, compare_c_triggers;
	logic capture_b_load_stops_clock, capture_b_load_disables_clock;
	logic compare_c_stops_clock, compare_c_disables_clock, ext_trigger_en;
	logic io_a_rise, io_b_rise, cap_b_load, ext_trigger, any_trigger;
	logic hw_disable, stop_event, active_edge, trig_fire, cmp_c_hit;
	logic clk_enabled, clk_running;

	// Word address match; low two address bits are ignored
	function automatic logic reg_hit(
		input logic [`TCC_ADDR_W-1:0] a,
		input logic [`TCC_ADDR_W-1:0] off
	);
		return a[`TCC_ADDR_W-1:2] == off[`TCC_ADDR_W-1:2];
	endfunction

	// ============================================================
	// APB slave: zero wait states, error on unmapped addresses
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign mapped = reg_hit(paddr, `TCC_OFF_CTRL) |
		reg_hit(paddr, `TCC_OFF_MODE) | reg_hit(paddr, `TCC_OFF_CMPC) |
		reg_hit(paddr, `TCC_OFF_CV) | reg_hit(paddr, `TCC_OFF_CAPB) |
		reg_hit(paddr, `TCC_OFF_STATUS);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_r;
	assign status_read = rd_acc & reg_hit(paddr, `TCC_OFF_STATUS);

	// Control register is write-only: each set bit is a one-cycle command
	assign clock_enable_cmd = wr_acc & reg_hit(paddr, `TCC_OFF_CTRL) &
		pwdata[`TCC_CTRL_EN_BIT];
	assign clock_disable_cmd = wr_acc & reg_hit(paddr, `TCC_OFF_CTRL) &
		pwdata[`TCC_CTRL_DIS_BIT];
	assign sw_trigger = wr_acc & reg_hit(paddr, `TCC_OFF_CTRL) &
		pwdata[`TCC_CTRL_SWTRG_BIT];

	// Mode and compare registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_mode_reg_r <= `TCC_MODE_RST;
			compare_register_c_r <= {COUNT_W{`TCC_CMPC_RST_BIT}};
		end else if (wr_acc && reg_hit(paddr, `TCC_OFF_MODE)) begin
			channel_mode_reg_r <= pwdata[`TCC_MODE_W-1:0];
		end else if (wr_acc && reg_hit(paddr, `TCC_OFF_CMPC)) begin
			compare_register_c_r <= pwdata[COUNT_W-1:0];
		end
	end

	// Status word; reserved bits read zero
	always_comb begin
		channel_status_reg = '0;
		channel_status_reg[`TCC_ST_ENABLED_BIT] = clk_enabled;
		channel_status_reg[`TCC_ST_RUN_BIT] = clk_running;
		channel_status_reg[`TCC_ST_LDB_BIT] = ldb_flag_r;
		channel_status_reg[`TCC_ST_CPC_BIT] = cpc_flag_r;
	end

	// Read mux, sampled into a flop during the setup phase
	always_comb begin
		rd_mux = '0;
		if (reg_hit(paddr, `TCC_OFF_MODE)) begin
			rd_mux[`TCC_MODE_W-1:0] = channel_mode_reg_r;
		end else if (reg_hit(paddr, `TCC_OFF_CMPC)) begin
			rd_mux[COUNT_W-1:0] = compare_register_c_r;
		end else if (reg_hit(paddr, `TCC_OFF_CV)) begin
			rd_mux[COUNT_W-1:0] = count;
		end else if (reg_hit(paddr, `TCC_OFF_CAPB)) begin
			rd_mux[COUNT_W-1:0] = capture_register_b_r;
		end else if (reg_hit(paddr, `TCC_OFF_STATUS)) begin
			rd_mux = channel_status_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= rd_mux;
		end
	end

	// ============================================================
	// Mode decode and channel line direction
	assign wave_mode = channel_mode_reg_r[`TCC_MODE_WAVE_BIT];
	assign capture_b_load_stops_clock =
		channel_mode_reg_r[`TCC_MODE_BSTOP_BIT];
	assign capture_b_load_disables_clock =
		channel_mode_reg_r[`TCC_MODE_BDIS_BIT];
	assign compare_c_stops_clock = channel_mode_reg_r[`TCC_MODE_CSTOP_BIT];
	assign compare_c_disables_clock =
		channel_mode_reg_r[`TCC_MODE_CDIS_BIT];
	assign compare_c_triggers = channel_mode_reg_r[`TCC_MODE_CPCTRG_BIT];
	assign ext_trigger_en = channel_mode_reg_r[`TCC_MODE_EXTTRG_BIT];

	assign channel_io_a_oe = wave_mode;
	assign channel_io_b_oe = wave_mode & ~ext_trigger_en;
	assign channel_io_a_out = io_a_out_r;
	assign channel_io_b_out = io_b_out_r;

	// Line edges; inputs are already synchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_a_prev_r <= 1'b0;
			io_b_prev_r <= 1'b0;
		end else begin
			io_a_prev_r <= channel_io_a_in;
			io_b_prev_r <= channel_io_b_in;
		end
	end
	assign io_a_rise = channel_io_a_in & ~io_a_prev_r;
	assign io_b_rise = channel_io_b_in & ~io_b_prev_r;

	// ============================================================
	// Events and trigger sources
	// Capture loads only while counting, else register B would hold stale 0
	assign cap_b_load = ~wave_mode & io_b_rise & clk_running;
	// External source: line A in capture, line B in waveform
	assign ext_trigger = ext_trigger_en &
		(wave_mode ? io_b_rise : io_a_rise);
	assign any_trigger = sw_trigger | sync_trigger | ext_trigger |
		(cmp_c_hit & compare_c_triggers);
	assign hw_disable = (cap_b_load & capture_b_load_disables_clock) |
		(cmp_c_hit & wave_mode & compare_c_disables_clock);
	assign stop_event = (cap_b_load & capture_b_load_stops_clock) |
		(cmp_c_hit & wave_mode & compare_c_stops_clock);

	// ============================================================
	// Clock gating state machine
	// Disable command wins over enable; an enable beats a hardware disable
	always_comb begin
		state_nxt = state_r;
		case (state_r)
		TCC_CLK_OFF: begin
			if (clock_enable_cmd && !clock_disable_cmd) begin
				state_nxt = TCC_CLK_STOP;
			end
		end
		TCC_CLK_STOP: begin
			if (clock_disable_cmd || (hw_disable && !clock_enable_cmd)) begin
				state_nxt = TCC_CLK_OFF;
			end else if (trig_fire) begin
				state_nxt = TCC_CLK_RUN;
			end
		end
		TCC_CLK_RUN: begin
			if (clock_disable_cmd || (hw_disable && !clock_enable_cmd)) begin
				state_nxt = TCC_CLK_OFF;
			end else if (trig_fire) begin
				state_nxt = TCC_CLK_RUN;
			end else if (stop_event) begin
				state_nxt = TCC_CLK_STOP;
			end
		end
		default: begin
			state_nxt = TCC_CLK_OFF;
		end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= TCC_CLK_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign clk_enabled = (state_r != TCC_CLK_OFF);
	assign clk_running = (state_r == TCC_CLK_RUN);

	// ============================================================
	// Counter core
	tcc_counter #(
		.COUNT_W(COUNT_W)
	) u_counter (
		.pclk(pclk),
		.presetn(presetn),
		.sel_clk(counter_clk),
		.trigger(any_trigger),
		.clk_enabled(clk_enabled),
		.clk_running(clk_running),
		.compare_c(compare_register_c_r),
		.active_edge(active_edge),
		.trig_fire(trig_fire),
		.cmp_c_hit(cmp_c_hit),
		.count(count)
	);

	// Capture register B
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_register_b_r <= '0;
		end else if (cap_b_load) begin
			capture_register_b_r <= count;
		end
	end

	// Sticky event flags; a read clears only the bits its word returned,
	// so an event between setup and access is not lost; a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ldb_flag_r <= 1'b0;
			cpc_flag_r <= 1'b0;
		end else begin
			ldb_flag_r <= cap_b_load |
				(ldb_flag_r & ~(status_read & prdata_r[`TCC_ST_LDB_BIT]));
			cpc_flag_r <= cmp_c_hit |
				(cpc_flag_r & ~(status_read & prdata_r[`TCC_ST_CPC_BIT]));
		end
	end

	// Minimal waveform: A toggles on compare C, B shows running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_a_out_r <= 1'b0;
			io_b_out_r <= 1'b0;
		end else begin
			io_b_out_r <= wave_mode & clk_running;
			if (!wave_mode) begin
				io_a_out_r <= 1'b0;
			end else if (cmp_c_hit) begin
				io_a_out_r <= ~io_a_out_r;
			end
		end
	end

	// ============================================================
	// Assertions
	property p_enable_cmd;
		@(posedge pclk) disable iff (!presetn)
		clock_enable_cmd && !clock_disable_cmd |=> clk_enabled;
	endproperty
	a_enable_cmd: assert property (p_enable_cmd)
		else $error("enable command did not enable the clock");

	property p_disable_cmd;
		@(posedge pclk) disable iff (!presetn)
		clock_disable_cmd |=> state_r == TCC_CLK_OFF ##1 !clk_running;
	endproperty
	a_disable_cmd: assert property (p_disable_cmd)
		else $error("disable command did not disable the clock");

	property p_ldb_disable;
		@(posedge pclk) disable iff (!presetn)
		io_b_rise && !wave_mode && clk_running &&
			capture_b_load_disables_clock && !clock_enable_cmd
		|=> state_r == TCC_CLK_OFF;
	endproperty
	a_ldb_disable: assert property (p_ldb_disable)
		else $error("register B load did not disable the clock");

	property p_cpc_disable;
		@(posedge pclk) disable iff (!presetn)
		cmp_c_hit && wave_mode && compare_c_disables_clock &&
			!clock_enable_cmd
		|=> state_r == TCC_CLK_OFF;
	endproperty
	a_cpc_disable: assert property (p_cpc_disable)
		else $error("compare C did not disable the clock");

	property p_off_holds;
		@(posedge pclk) disable iff (!presetn)
		!clk_enabled && !clock_enable_cmd |=> !clk_enabled;
	endproperty
	a_off_holds: assert property (p_off_holds)
		else $error("clock left the disabled state without a command");

	property p_status_read;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && reg_hit(paddr, `TCC_OFF_STATUS)
		|=> prdata[`TCC_ST_ENABLED_BIT] == $past(clk_enabled);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read does not show the enable state");

	property p_trig_start;
		@(posedge pclk) disable iff (!presetn)
		trig_fire && !clock_disable_cmd && !hw_disable
		|=> clk_running && count == '0;
	endproperty
	a_trig_start: assert property (p_trig_start)
		else $error("trigger did not clear and start the counter");

	property p_ldb_stop;
		@(posedge pclk) disable iff (!presetn)
		cap_b_load && capture_b_load_stops_clock && !hw_disable &&
			!trig_fire && !clock_disable_cmd
		|=> state_r == TCC_CLK_STOP;
	endproperty
	a_ldb_stop: assert property (p_ldb_stop)
		else $error("register B load did not stop the clock");

	property p_cpc_stop;
		@(posedge pclk) disable iff (!presetn)
		cmp_c_hit && wave_mode && compare_c_stops_clock && !hw_disable &&
			!trig_fire && !clock_disable_cmd && clk_running
		|=> state_r == TCC_CLK_STOP;
	endproperty
	a_cpc_stop: assert property (p_cpc_stop)
		else $error("compare C did not stop the clock");

	property p_line_dir;
		@(posedge pclk) disable iff (!presetn)
		(!wave_mode |-> !channel_io_a_oe && !channel_io_b_oe) and
		(wave_mode |-> channel_io_a_oe &&
			(channel_io_b_oe == !ext_trigger_en));
	endproperty
	a_line_dir: assert property (p_line_dir)
		else $error("channel line direction wrong for the mode");

	property p_count_step;
		@(posedge pclk) disable iff (!presetn)
		active_edge && clk_running && !trig_fire
		|=> count == $past(count) + 1'b1;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not step on an active edge");

	property p_trig_waits;
		@(posedge pclk) disable iff (!presetn)
		clk_enabled && !clk_running && !active_edge && !clock_disable_cmd
		|=> !clk_running;
	endproperty
	a_trig_waits: assert property (p_trig_waits)
		else $error("clock started without an active edge");

	c_trig_run: cover property (@(posedge pclk) disable iff (!presetn)
		trig_fire ##1 clk_running);
	c_cpc_stop: cover property (@(posedge pclk) disable iff (!presetn)
		cmp_c_hit && wave_mode ##1 state_r == TCC_CLK_STOP);
	c_ldb_load: cover property (@(posedge pclk) disable iff (!presetn)
		cap_b_load);
	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
		pslverr);

endmodule // tcc_channel

// >>> verification/tcc_line_model.sv
// Far-end sources on the two channel lines, resolved against the channel
`timescale 1ns/1ns
module tcc_line_model (
	input wire logic ext_a,
	input wire logic ext_b,
	input wire logic a_out,
	input wire logic a_oe,
	input wire logic b_out,
	input wire logic b_oe,
	output logic a_wire,
	output logic b_wire
);
	// The channel owns a line while it drives it; the far source otherwise
	// keeps driving, so the wire is never left floating
	assign a_wire = a_oe ? a_out : ext_a;
	assign b_wire = b_oe ? b_out : ext_b;
endmodule // tcc_line_model

// >>> verification/timer_channel_clock_trigger_ctrl_tb.sv
// Self-checking bench for the timer channel clock and trigger control
`timescale 1ns/1ns
`include "tcc_consts.svh"
module timer_channel_clock_trigger_ctrl_tb import tcc_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, rnd_state, mode_w;
	logic counter_clk, sync_trigger, ext_a, ext_b, e;
	logic a_in, a_out, a_oe, b_in, b_out, b_oe;
	int errors, n_checks, k;

	// ============================================================
	// Design and far-end model
	tcc_channel #(.COUNT_W(16)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .counter_clk(counter_clk),
		.sync_trigger(sync_trigger), .channel_io_a_in(a_in),
		.channel_io_a_out(a_out), .channel_io_a_oe(a_oe),
		.channel_io_b_in(b_in), .channel_io_b_out(b_out),
		.channel_io_b_oe(b_oe));
	tcc_line_model far (.ext_a(ext_a), .ext_b(ext_b), .a_out(a_out),
		.a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .a_wire(a_in),
		.b_wire(b_in));

	// 25 MHz bus clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ============================================================
	// Expectation helpers
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Line A drives in waveform; line B too unless it is the trigger input
	function automatic logic [31:0] exp_oe(input logic [31:0] m);
		return {30'h0, m[0], m[0] & ~m[6]};
	endfunction

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ============================================================
	// APB master: hold the request until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait states, if any, are bounded by the bench watchdog alone
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a,
		input logic [31:0] exp, input logic [31:0] mask);
		apb(1'b0, a, 32'h0);
		check(nm, q & mask, exp);
	endtask

	// Rising edges of the counter clock, each high two cycles and low three
	task automatic edges(input int n);
		repeat (n) begin
			@(posedge pclk);
			counter_clk <= 1'b1;
			repeat (2) @(posedge pclk);
			counter_clk <= 1'b0;
			repeat (2) @(posedge pclk);
		end
		repeat (3) @(posedge pclk);
	endtask

	// Far source makes a clean low-to-high step on one line
	task automatic line_rise(input logic on_b);
		@(posedge pclk);
		if (on_b) ext_b <= 1'b0;
		else ext_a <= 1'b0;
		repeat (3) @(posedge pclk);
		if (on_b) ext_b <= 1'b1;
		else ext_a <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask

	// Hang guard, far beyond the length of the sequence
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		results();
	end

	// ============================================================
	// Main sequence
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, counter_clk, sync_trigger} = 5'h0;
		{ext_a, ext_b} = 2'b00;
		paddr = 8'h00;
		pwdata = 32'h0;
		rnd_state = 32'hd0c87333;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check("oe after reset", {30'h0, a_oe, b_oe}, 32'h0);
		rd_chk("mode", `TCC_OFF_MODE, 32'h0, 32'hffffffff);
		rd_chk("cmp c", `TCC_OFF_CMPC, 32'hffff, 32'hffffffff);
		rd_chk("status", `TCC_OFF_STATUS, 32'h0, 32'h3);
		apb(1'b0, 8'h18, 32'h0);
		check("unmapped err", {31'h0, e}, 32'h1);
		check("unmapped data", q, 32'h0);
		$display("test reset done");

		// Triggers while disabled do nothing
		apb(1'b1, `TCC_OFF_CTRL, 32'h4);
		@(posedge pclk) sync_trigger <= 1'b1;
		@(posedge pclk) sync_trigger <= 1'b0;
		edges(2);
		rd_chk("cv disabled", `TCC_OFF_CV, 32'h0, 32'hffff);
		rd_chk("st disabled", `TCC_OFF_STATUS, 32'h0, 32'h3);
		// Enable, then a sync trigger acts only at the next active edge
		apb(1'b1, `TCC_OFF_CTRL, 32'h1);
		rd_chk("st enabled", `TCC_OFF_STATUS, 32'h1, 32'h3);
		@(posedge pclk) sync_trigger <= 1'b1;
		@(posedge pclk) sync_trigger <= 1'b0;
		repeat (3) @(posedge pclk);
		rd_chk("st pending", `TCC_OFF_STATUS, 32'h1, 32'h3);
		edges(1);
		rd_chk("st run", `TCC_OFF_STATUS, 32'h3, 32'h3);
		rd_chk("cv trig", `TCC_OFF_CV, 32'h0, 32'hffff);
		rnd_state = lfsr_next(rnd_state);
		k = int'(rnd_state[2:0]) + 1;
		edges(k);
		rd_chk("cv count", `TCC_OFF_CV, k, 32'hffff);
		// Software trigger restarts from zero; disable freezes the count
		apb(1'b1, `TCC_OFF_CTRL, 32'h4);
		edges(3);
		rd_chk("cv sw trig", `TCC_OFF_CV, 32'h2, 32'hffff);
		apb(1'b1, `TCC_OFF_CTRL, 32'h2);
		rd_chk("st dis", `TCC_OFF_STATUS, 32'h0, 32'h3);
		edges(2);
		rd_chk("cv frozen", `TCC_OFF_CV, 32'h2, 32'hffff);
		apb(1'b1, `TCC_OFF_CTRL, 32'h1);
		edges(1);
		rd_chk("st reen", `TCC_OFF_STATUS, 32'h1, 32'h3);
		rd_chk("cv reen", `TCC_OFF_CV, 32'h2, 32'hffff);
		$display("test enable and trigger done");

		// Line directions for every combination of mode and ext trigger
		for (int i = 0; i < 4; i++) begin
			mode_w = {25'h0, i[1], 5'h0, i[0]};
			apb(1'b1, `TCC_OFF_MODE, mode_w);
			// The mode flop settles after the access edge; look mid-cycle
			@(negedge pclk);
			check("oe", {30'h0, a_oe, b_oe}, exp_oe(mode_w));
			rd_chk("mode back", `TCC_OFF_MODE, mode_w, 32'h7f);
		end
		$display("test modes done");

		// Compare C stops, retriggers and disables in waveform mode
		apb(1'b1, `TCC_OFF_CMPC, 32'h3);
		apb(1'b1, `TCC_OFF_MODE, 32'h09);
		apb(1'b1, `TCC_OFF_CTRL, 32'h4);
		edges(6);
		rd_chk("cv stop", `TCC_OFF_CV, 32'h3, 32'hffff);
		rd_chk("st stop", `TCC_OFF_STATUS, 32'h9, 32'hf);
		check("line out", {30'h0, a_out, b_out}, 32'h2);
		apb(1'b1, `TCC_OFF_MODE, 32'h21);
		apb(1'b1, `TCC_OFF_CTRL, 32'h4);
		edges(5);
		rd_chk("cv cmp trig", `TCC_OFF_CV, 32'h0, 32'hffff);
		apb(1'b1, `TCC_OFF_MODE, 32'h11);
		apb(1'b1, `TCC_OFF_CTRL, 32'h4);
		edges(6);
		rd_chk("st cmp dis", `TCC_OFF_STATUS, 32'h0, 32'h3);
		// Line B rise is the external trigger in waveform mode
		apb(1'b1, `TCC_OFF_CTRL, 32'h1);
		apb(1'b1, `TCC_OFF_MODE, 32'h41);
		line_rise(1'b1);
		edges(1);
		rd_chk("st ext b", `TCC_OFF_STATUS, 32'h3, 32'h3);
		rd_chk("cv ext b", `TCC_OFF_CV, 32'h0, 32'hffff);
		$display("test waveform done");

		// Capture mode: B load stops, line A triggers, B load disables
		apb(1'b1, `TCC_OFF_MODE, 32'h02);
		apb(1'b1, `TCC_OFF_CTRL, 32'h4);
		edges(2);
		line_rise(1'b1);
		rd_chk("st ldb stop", `TCC_OFF_STATUS, 32'h5, 32'hf);
		rd_chk("capture b", `TCC_OFF_CAPB, 32'h1, 32'hffff);
		apb(1'b1, `TCC_OFF_MODE, 32'h44);
		line_rise(1'b0);
		edges(1);
		rd_chk("st ext a", `TCC_OFF_STATUS, 32'h3, 32'h3);
		line_rise(1'b1);
		rd_chk("st ldb dis", `TCC_OFF_STATUS, 32'h0, 32'h3);
		$display("test capture done");

		// Reset in mid-run returns everything to its start state
		@(posedge pclk) presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("mode rst", `TCC_OFF_MODE, 32'h0, 32'hffffffff);
		rd_chk("st rst", `TCC_OFF_STATUS, 32'h0, 32'h3);
		$display("test mid reset done");
		results();
	end
endmodule // timer_channel_clock_trigger_ctrl_tb
